// >>> hw/difc_regs.svh
`ifndef DIFC_REGS_SVH
`define DIFC_REGS_SVH

// ----------------------------------------------------------------
// Clock and lookahead timing
// ----------------------------------------------------------------
`define DIFC_CLK_MHZ 50
`define DIFC_LOOKAHEAD_NS 100
`define DIFC_LOOKAHEAD_CYC ((`DIFC_LOOKAHEAD_NS * `DIFC_CLK_MHZ) / 1000)
`define DIFC_QUIET_US 100
`define DIFC_QUIET_CYC (`DIFC_QUIET_US * `DIFC_CLK_MHZ)

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define DIFC_ADC_W 14
`define DIFC_ENV_W 12
`define DIFC_GAIN_W 2
`define DIFC_HOLD_W 3
`define DIFC_QCNT_W 16
`define DIFC_GAIN_LAT 4
`define DIFC_IQ_W 18
`define DIFC_BST_W 19
`define DIFC_FIR_W 23
`define DIFC_TAPS 5
`define DIFC_ACC_W 27
`define DIFC_MAG_W 28
`define DIFC_PH_W 3
`define DIFC_SEL_W 8
`define DIFC_VSH_W 4
`define DIFC_OUT_W (2 * `DIFC_MAG_W + `DIFC_PH_W)
`define DIFC_OUT_A_LSB (`DIFC_MAG_W + `DIFC_PH_W)
`define DIFC_OUT_B_LSB `DIFC_PH_W
`define DIFC_BUF_DEPTH 2

// ----------------------------------------------------------------
// Gain control values
// ----------------------------------------------------------------
`define DIFC_GAIN_MIN 2'h0
`define DIFC_GAIN_MAX 2'h3
`define DIFC_GAIN_ONE 2'h1
`define DIFC_ENV_HI 12'hE00
`define DIFC_ENV_LO 12'h600
`define DIFC_DEC_HOLD 3'h5

// ----------------------------------------------------------------
// Filter and decimation values
// ----------------------------------------------------------------
`define DIFC_FIR_SH 4
`define DIFC_FIR_C1 23'h000004
`define DIFC_FIR_C2 23'h000006
`define DIFC_RBW_LAST 8'h9F
`define DIFC_FFT_MIN_LAST 8'h01
`define DIFC_CNT_ONE 8'h01

`endif

// >>> hw/difc_pkg.sv
package difc_pkg;
`include "difc_regs.svh"

	typedef logic signed [`DIFC_IQ_W-1:0] difc_iq_t;
	typedef logic signed [`DIFC_BST_W-1:0] difc_bst_t;
	typedef logic signed [`DIFC_FIR_W-1:0] difc_fir_t;
	typedef logic signed [`DIFC_ACC_W-1:0] difc_acc_t;

	typedef struct packed {
		logic [`DIFC_ADC_W-1:0] adc1;
		logic [`DIFC_ADC_W-1:0] adc2;
		logic strb1;
		logic strb2;
		logic strb3;
		logic [`DIFC_ENV_W-1:0] env1;
		logic [`DIFC_ENV_W-1:0] env2;
		logic [`DIFC_GAIN_W-1:0] gain;
		logic [`DIFC_HOLD_W-1:0] hold;
		logic [`DIFC_QCNT_W-1:0] quiet;
		logic [`DIFC_GAIN_LAT-1:0][`DIFC_GAIN_W-1:0] gainHist;
		logic phase;
		logic sign;
		difc_iq_t heldI;
		difc_iq_t prevI;
		difc_iq_t prevQ;
		logic [`DIFC_TAPS-1:0][`DIFC_BST_W-1:0] tapI;
		logic [`DIFC_TAPS-1:0][`DIFC_BST_W-1:0] tapQ;
		logic firEn;
		difc_acc_t accI;
		difc_acc_t accQ;
		logic [`DIFC_SEL_W-1:0] decCnt;
		logic [`DIFC_MAG_W-1:0] video;
		logic pend;
		logic [`DIFC_OUT_W-1:0] word;
		logic overrun;
	} difc_state_t;
endpackage

// >>> hw/difc_pair_buf.sv
`timescale 1ns/1ps
module difc_pair_buf #(
	parameter int W = 59,
	parameter int DEPTH = 2
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} difc_fifo_t;

	difc_fifo_t s;
	difc_fifo_t n;
	logic push;
	logic pop;

	assign inReady = (s.cnt != FULL);
	assign outValid = (s.cnt != '0);
	assign outData = s.mem[s.rp];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	always_comb begin
		n = s;
		if (push) begin
			n.mem[s.wp] = inData;
			n.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
		end
		if (pop) begin
			n.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
		end
		if (push && !pop) begin
			n.cnt = s.cnt + 1'b1;
		end else if (pop && !push) begin
			n.cnt = s.cnt - 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule

// >>> hw/difc_chain.sv
`timescale 1ns/1ps
`include "difc_regs.svh"
module difc_chain
	import difc_pkg::*;
#(
	parameter int QUIET_HOLD = `DIFC_QUIET_CYC
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [`DIFC_ADC_W-1:0] adcData,
	input wire logic adcStrobe,
	input wire logic [`DIFC_ENV_W-1:0] autorangeEnv,
	input wire logic autorangeEnable,
	input wire logic sweptMode,
	input wire logic [`DIFC_SEL_W-1:0] resolutionBandwidthSel,
	input wire logic [`DIFC_VSH_W-1:0] videoSmoothingBandwidthShift,
	output logic [`DIFC_GAIN_W-1:0] analogGain,
	output logic outValid,
	input wire logic outReady,
	output logic [`DIFC_MAG_W-1:0] outA,
	output logic [`DIFC_MAG_W-1:0] outB,
	output logic [`DIFC_PH_W-1:0] outPhase,
	output logic overrun
);
	localparam logic [`DIFC_QCNT_W-1:0] QUIET_LAST =
		`DIFC_QCNT_W'(QUIET_HOLD - 1);

	difc_state_t s;
	difc_state_t n;
	logic sampleEn;
	logic pairEn;
	logic dump;
	logic bufReady;
	logic [`DIFC_OUT_W-1:0] bufData;
	logic [`DIFC_GAIN_W-1:0] appliedGain;
	logic [`DIFC_SEL_W-1:0] selClamp;
	logic [`DIFC_SEL_W-1:0] lastCnt;
	logic signed [`DIFC_ADC_W+2:0] comp;
	difc_iq_t iNow;
	difc_iq_t qNow;
	difc_bst_t boostI;
	difc_bst_t boostQ;
	difc_fir_t firI;
	difc_fir_t firQ;
	difc_acc_t accNewI;
	difc_acc_t accNewQ;
	logic [`DIFC_ACC_W-1:0] absI;
	logic [`DIFC_ACC_W-1:0] absQ;
	logic [`DIFC_MAG_W-1:0] mag;
	logic signed [`DIFC_MAG_W:0] vDiff;
	logic signed [`DIFC_MAG_W:0] vSum;

	function automatic difc_fir_t fir5(
		input logic [`DIFC_TAPS-1:0][`DIFC_BST_W-1:0] t
	);
		difc_fir_t e0;
		difc_fir_t e1;
		difc_fir_t e2;
		difc_fir_t e3;
		difc_fir_t e4;
		e0 = `DIFC_FIR_W'($signed(t[0]));
		e1 = `DIFC_FIR_W'($signed(t[1]));
		e2 = `DIFC_FIR_W'($signed(t[2]));
		e3 = `DIFC_FIR_W'($signed(t[3]));
		e4 = `DIFC_FIR_W'($signed(t[4]));
		// Binomial taps: symmetric, so linear phase
		fir5 = e0 + e4 + `DIFC_FIR_C1 * (e1 + e3) + `DIFC_FIR_C2 * e2;
	endfunction

	// ----------------------------------------------------------------
	// Output buffer
	// ----------------------------------------------------------------
	difc_pair_buf #(
		.W(`DIFC_OUT_W),
		.DEPTH(`DIFC_BUF_DEPTH)
	) u_buf (
		.clock(clock),
		.nrst(nrst),
		.inValid(s.pend),
		.inReady(bufReady),
		.inData(s.word),
		.outValid(outValid),
		.outReady(outReady),
		.outData(bufData)
	);

	assign outA = bufData[`DIFC_OUT_A_LSB +: `DIFC_MAG_W];
	assign outB = bufData[`DIFC_OUT_B_LSB +: `DIFC_MAG_W];
	assign outPhase = bufData[`DIFC_PH_W-1:0];
	assign analogGain = s.gain;
	assign overrun = s.overrun;
	assign sampleEn = s.strb2 & ~s.strb3;
	assign pairEn = sampleEn & s.phase;
	assign appliedGain = s.gainHist[`DIFC_GAIN_LAT-1];

	// ----------------------------------------------------------------
	// Datapath and control
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		n.adc1 = adcData;
		n.adc2 = s.adc1;
		n.strb1 = adcStrobe;
		n.strb2 = s.strb1;
		n.strb3 = s.strb2;
		n.env1 = autorangeEnv;
		n.env2 = s.env1;

		// Autorange, decided every clock from the early detector
		if (!autorangeEnable) begin
			n.gain = `DIFC_GAIN_MIN;
			n.hold = '0;
			n.quiet = '0;
		end else if (s.env2 > `DIFC_ENV_HI) begin
			n.quiet = '0;
			if (s.hold != '0) begin
				n.hold = s.hold - 1'b1;
			end else if (s.gain != `DIFC_GAIN_MIN) begin
				n.gain = s.gain - `DIFC_GAIN_ONE;
				n.hold = `DIFC_DEC_HOLD;
			end
		end else begin
			if (s.hold != '0) begin
				n.hold = s.hold - 1'b1;
			end
			if (s.env2 >= `DIFC_ENV_LO) begin
				n.quiet = '0;
			end else if (s.quiet >= QUIET_LAST) begin
				n.quiet = '0;
				if (s.gain != `DIFC_GAIN_MAX) begin
					n.gain = s.gain + `DIFC_GAIN_ONE;
				end
			end else begin
				n.quiet = s.quiet + 1'b1;
			end
		end

		// Digital gain opposite to the delayed analog gain
		comp = $signed({{3{s.adc2[`DIFC_ADC_W-1]}}, s.adc2})
			<<< (`DIFC_GAIN_MAX - appliedGain);

		// fs/4 downmix: I from even samples, Q from odd
		iNow = s.sign ? -s.heldI : s.heldI;
		qNow = s.sign ? `DIFC_IQ_W'(comp) : -`DIFC_IQ_W'(comp);

		// Inverse single-pole boost: 2x[n] - x[n-1]
		boostI = (`DIFC_BST_W'(iNow) <<< 1) - `DIFC_BST_W'(s.prevI);
		boostQ = (`DIFC_BST_W'(qNow) <<< 1) - `DIFC_BST_W'(s.prevQ);

		if (sampleEn) begin
			n.gainHist = {s.gainHist[`DIFC_GAIN_LAT-2:0], s.gain};
			n.phase = ~s.phase;
			if (!s.phase) begin
				n.heldI = `DIFC_IQ_W'(comp);
			end else begin
				n.sign = ~s.sign;
				n.prevI = iNow;
				n.prevQ = qNow;
				n.tapI = {s.tapI[`DIFC_TAPS-2:0], boostI};
				n.tapQ = {s.tapQ[`DIFC_TAPS-2:0], boostQ};
			end
		end
		n.firEn = pairEn;

		// Gaussian-like response: binomial FIR then boxcar
		firI = fir5(s.tapI) >>> `DIFC_FIR_SH;
		firQ = fir5(s.tapQ) >>> `DIFC_FIR_SH;
		accNewI = s.accI + `DIFC_ACC_W'(firI);
		accNewQ = s.accQ + `DIFC_ACC_W'(firQ);

		// 160 bandwidths from the decimation length
		selClamp = (resolutionBandwidthSel > `DIFC_RBW_LAST) ?
			`DIFC_RBW_LAST : resolutionBandwidthSel;
		// FFT mode decimates at least by two: 7.5 MHz span
		lastCnt = (!sweptMode && selClamp < `DIFC_FFT_MIN_LAST) ?
			`DIFC_FFT_MIN_LAST : selClamp;
		dump = s.firEn && (s.decCnt == lastCnt);

		// Magnitude and octant phase
		absI = accNewI[`DIFC_ACC_W-1] ? `DIFC_ACC_W'(-accNewI) : accNewI;
		absQ = accNewQ[`DIFC_ACC_W-1] ? `DIFC_ACC_W'(-accNewQ) : accNewQ;
		if (absI >= absQ) begin
			mag = {1'b0, absI} + {2'b00, absQ[`DIFC_ACC_W-1:1]};
		end else begin
			mag = {1'b0, absQ} + {2'b00, absI[`DIFC_ACC_W-1:1]};
		end

		// Video smoothing, one-pole toward the magnitude
		vDiff = $signed({1'b0, mag}) - $signed({1'b0, s.video});
		vSum = $signed({1'b0, s.video})
			+ (vDiff >>> videoSmoothingBandwidthShift);

		if (s.pend && bufReady) begin
			n.pend = 1'b0;
		end
		if (s.firEn) begin
			if (dump) begin
				n.accI = '0;
				n.accQ = '0;
				n.decCnt = '0;
				if (sweptMode) begin
					n.video = vSum[`DIFC_MAG_W-1:0];
				end
				if (!s.pend || bufReady) begin
					n.pend = 1'b1;
					if (sweptMode) begin
						n.word = {vSum[`DIFC_MAG_W-1:0], mag,
							accNewI[`DIFC_ACC_W-1],
							accNewQ[`DIFC_ACC_W-1],
							absQ > absI};
					end else begin
						n.word = {`DIFC_MAG_W'(accNewI),
							`DIFC_MAG_W'(accNewQ),
							`DIFC_PH_W'(0)};
					end
				end else begin
					n.overrun = 1'b1;
				end
			end else begin
				n.accI = accNewI;
				n.accQ = accNewQ;
				n.decCnt = s.decCnt + `DIFC_CNT_ONE;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	a_gain_drop: assert property (
		(autorangeEnable && s.env2 > `DIFC_ENV_HI && s.hold == '0
			&& s.gain != `DIFC_GAIN_MIN)
		|=> (s.gain == $past(s.gain) - `DIFC_GAIN_ONE)
			&& (s.hold == `DIFC_DEC_HOLD))
		else $error("gain not lowered on large envelope");

	// No quiet-interval raise may land inside the window
	a_gain_lookahead: assert property (
		(autorangeEnable && s.hold == '0 && s.gain != `DIFC_GAIN_MIN
			&& autorangeEnv > `DIFC_ENV_HI
			&& (s.gain == `DIFC_GAIN_MAX || s.quiet + 1'b1 < QUIET_LAST))
		##1 (autorangeEnable && autorangeEnv > `DIFC_ENV_HI)
		##1 (autorangeEnable && autorangeEnv > `DIFC_ENV_HI)
		|=> analogGain < $past(analogGain, 3))
		else $error("gain decision missed the lookahead window");

	a_gain_raise: assert property (
		(autorangeEnable && s.env2 < `DIFC_ENV_LO
			&& s.quiet >= QUIET_LAST && s.gain != `DIFC_GAIN_MAX)
		|=> s.gain == $past(s.gain) + `DIFC_GAIN_ONE)
		else $error("gain not raised after quiet interval");

	a_comp_scale: assert property (
		sampleEn |-> ((comp >>> (`DIFC_GAIN_MAX - appliedGain))
			== $signed(s.adc2)))
		else $error("digital gain does not cancel analog gain");

	a_comp_align: assert property (
		$changed(appliedGain) |-> $past(sampleEn)
			&& appliedGain == $past(s.gainHist[`DIFC_GAIN_LAT-2]))
		else $error("digital gain moved off the sample grid");

	a_pair_rate: assert property (
		pairEn |=> !pairEn ##1 !pairEn)
		else $error("pairs faster than half the sample rate");

	a_boost_step: assert property (
		pairEn |=> $signed(s.tapI[0])
			== (`DIFC_BST_W'($past(iNow)) <<< 1)
			- `DIFC_BST_W'($past(s.prevI)))
		else $error("boost stage output wrong");

	a_dump_count: assert property (
		(s.firEn && s.decCnt == lastCnt && !s.pend) |=> s.pend
			&& s.accI == '0 && s.decCnt == '0)
		else $error("decimated word not issued");

	a_fft_span: assert property (
		!sweptMode |-> lastCnt >= `DIFC_FFT_MIN_LAST)
		else $error("fft span wider than anti-alias band");

	a_mag_bound: assert property (
		s.firEn |-> mag >= {1'b0, absI} && mag >= {1'b0, absQ}
			&& mag <= {1'b0, absI} + {1'b0, absQ})
		else $error("magnitude estimate out of bounds");
endmodule

// >>> sim/difc_sink.sv
`timescale 1ns/1ps
`include "difc_regs.svh"
module difc_sink (
	input wire logic clock,
	input wire logic nrst,
	input wire logic outValid,
	output logic outReady,
	input wire logic [`DIFC_MAG_W-1:0] outA,
	input wire logic [`DIFC_MAG_W-1:0] outB,
	input wire logic [`DIFC_PH_W-1:0] outPhase,
	input wire logic stall,
	input wire logic slow
);
	logic [`DIFC_MAG_W-1:0] lastA;
	logic [`DIFC_MAG_W-1:0] lastB;
	logic [`DIFC_PH_W-1:0] lastPh;
	logic tick;
	int got;

	// ----------------------------------------
	// Consumer, kept raw and unscaled
	// ----------------------------------------
	always @(posedge clock) begin
		if (!nrst) begin
			got <= 0;
			tick <= 1'b0;
			outReady <= 1'b0;
		end else begin
			tick <= !tick;
			outReady <= !stall && (!slow || tick);
			if (outValid && outReady) begin
				got <= got + 1;
				lastA <= outA;
				lastB <= outB;
				lastPh <= outPhase;
			end
		end
	end
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
`include "difc_regs.svh"
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin \
	errorCnt++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
	end end
module tb;
	localparam int QH = 100;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [`DIFC_ADC_W-1:0] adcData = '0;
	logic adcStrobe = 1'b0;
	logic [`DIFC_ENV_W-1:0] env = 12'h700;
	logic arEn = 1'b0;
	logic swept = 1'b0;
	logic [`DIFC_SEL_W-1:0] rbwSel = 8'h03;
	logic [`DIFC_VSH_W-1:0] vShift = 4'h0;
	logic outValid, outReady, overrun;
	logic stall = 1'b0;
	logic slow = 1'b0;
	logic run = 1'b0;
	logic [`DIFC_GAIN_W-1:0] analogGain;
	logic [`DIFC_MAG_W-1:0] outA, outB;
	logic [`DIFC_PH_W-1:0] outPhase;
	logic [1:0] ph;
	int k, amI, amQ, gs, p, v;
	int errorCnt = 0;
	int samplesChecked = 0;

	difc_chain #(.QUIET_HOLD(QH)) uut (.clock(clock), .nrst(nrst),
		.adcData(adcData), .adcStrobe(adcStrobe), .autorangeEnv(env),
		.autorangeEnable(arEn), .sweptMode(swept),
		.resolutionBandwidthSel(rbwSel),
		.videoSmoothingBandwidthShift(vShift), .analogGain(analogGain),
		.outValid(outValid), .outReady(outReady), .outA(outA),
		.outB(outB), .outPhase(outPhase), .overrun(overrun));
	difc_sink u_sink (.clock(clock), .nrst(nrst), .outValid(outValid),
		.outReady(outReady), .outA(outA), .outB(outB),
		.outPhase(outPhase), .stall(stall), .slow(slow));

	always #10 clock = !clock;

	// ----------------------------------------
	// Sample source, I/Q pre-rotated, scaled by gain
	// ----------------------------------------
	always @(posedge clock) begin
		if (!nrst || !run) begin
			ph <= 2'h0;
			k <= 0;
			adcStrobe <= 1'b0;
		end else begin
			ph <= ph + 2'h1;
			p = k >> 1;
			v = k[0] ? (p[0] ? amQ : -amQ) : (p[0] ? -amI : amI);
			if (ph == 2'h3) adcStrobe <= 1'b1;
			if (ph == 2'h1) begin
				adcStrobe <= 1'b0;
				adcData <= `DIFC_ADC_W'(v <<< gs);
				k <= k + 1;
			end
		end
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", samplesChecked, errorCnt);
		if (errorCnt == 0 && samplesChecked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic do_reset;
		@(posedge clock);
		nrst <= 1'b0;
		run <= 1'b0;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
	endtask

	task automatic stream(input int sel, ai, aq, g, input logic sw,
		input int ea, eb, input logic [2:0] ep);
		int t;
		int b;
		@(posedge clock);
		rbwSel <= 8'(sel);
		swept <= sw;
		amI = ai;
		amQ = aq;
		gs = g;
		run <= 1'b1;
		for (int w = 0; w < 9; w++) begin
			t = 0;
			b = u_sink.got;
			while (u_sink.got == b && t < 3000) begin
				@(posedge clock);
				t++;
			end
			#1;
			`CHK("word arrives", 1'b1, t < 3000)
			if (w > 3) begin
				`CHK("outA", 28'(ea), u_sink.lastA)
				`CHK("outB", 28'(eb), u_sink.lastB)
				`CHK("outPhase", ep, u_sink.lastPh)
			end
		end
		run <= 1'b0;
	endtask

	task automatic climb;
		int n;
		do_reset();
		arEn <= 1'b1;
		env <= 12'h100;
		n = 0;
		while (analogGain === 2'h0 && n < 400) begin
			@(posedge clock);
			#1;
			n++;
		end
		`CHK("quiet span", 1'b1, n >= QH && n <= QH + 5)
		while (analogGain !== 2'h3 && n < 800) begin
			@(posedge clock);
			#1;
			n++;
		end
		`CHK("top gain", 2'h3, analogGain)
		@(posedge clock);
		env <= 12'h700;
	endtask

	task automatic t_reset;
		do_reset();
		#1;
		`CHK("gain", 2'h0, analogGain)
		`CHK("valid", 1'b0, outValid)
		`CHK("outA", 28'h0, outA)
		`CHK("overrun", 1'b0, overrun)
		$display("test reset done");
	endtask

	task automatic t_autorange;
		climb();
		@(posedge clock);
		env <= 12'hF00;
		repeat (2) @(posedge clock);
		#1 `CHK("gain before", 2'h3, analogGain)
		@(posedge clock);
		#1 `CHK("gain drop", 2'h2, analogGain)
		repeat (4) @(posedge clock);
		#1 `CHK("gain held", 2'h2, analogGain)
		repeat (3) @(posedge clock);
		#1 `CHK("gain drop 2", 2'h1, analogGain)
		@(posedge clock);
		arEn <= 1'b0;
		repeat (2) @(posedge clock);
		#1 `CHK("gain off", 2'h0, analogGain)
		$display("test autorange done");
	endtask

	task automatic t_gain_comp;
		climb();
		stream(3, 100, 50, 3, 1'b0, 3200, 1600, 3'h0);
		arEn <= 1'b0;
		$display("test gain compensation done");
	endtask

	task automatic t_fft;
		int sels[3] = '{0, 3, 255};
		int n;
		slow = 1'b1;
		foreach (sels[i]) begin
			n = (sels[i] > 159 ? 159 : sels[i]) + 1;
			if (n < 2) n = 2;
			do_reset();
			stream(sels[i], 100, -50, 0, 1'b0, n * 800, -n * 400,
				3'h0);
		end
		slow = 1'b0;
		$display("test fft lengths done");
	endtask

	task automatic t_swept;
		do_reset();
		stream(3, -40, 100, 0, 1'b1, 3840, 3840, 3'h5);
		// Narrow smoothing: video stays at its reset level
		do_reset();
		vShift <= 4'hC;
		stream(3, -40, 100, 0, 1'b1, 0, 3840, 3'h5);
		vShift <= 4'h0;
		$display("test swept done");
	endtask

	task automatic t_overrun;
		logic [`DIFC_MAG_W-1:0] held;
		int t;
		int b;
		do_reset();
		stall <= 1'b1;
		@(posedge clock);
		rbwSel <= 8'h00;
		swept <= 1'b0;
		amI = 20;
		amQ = 20;
		gs = 0;
		run <= 1'b1;
		t = 0;
		while (outValid !== 1'b1 && t < 500) begin
			@(posedge clock);
			#1;
			t++;
		end
		`CHK("first word", 1'b1, t < 500)
		held = outA;
		repeat (10) @(posedge clock);
		#1 `CHK("word stands", held, outA)
		`CHK("no overrun yet", 1'b0, overrun)
		repeat (80) @(posedge clock);
		#1 `CHK("overrun set", 1'b1, overrun)
		b = u_sink.got;
		stall <= 1'b0;
		repeat (40) @(posedge clock);
		#1 `CHK("drained", 1'b1, u_sink.got >= b + 3)
		`CHK("overrun sticky", 1'b1, overrun)
		run <= 1'b0;
		do_reset();
		#1 `CHK("overrun cleared", 1'b0, overrun)
		$display("test overrun done");
	endtask

	initial begin
		repeat (40000) @(posedge clock);
		errorCnt++;
		close_out();
	end

	initial begin
		t_reset();
		t_autorange();
		t_gain_comp();
		t_fft();
		t_swept();
		t_overrun();
		close_out();
	end
endmodule
